//--- common/csc_pkg.sv
// shared constants and types of the capacitive sense control ends
package csc_pkg;
  // sense control 0 field positions and control 1 channel field width
  localparam int unsigned EN_BIT    = 7;
  localparam int unsigned RM_BIT    = 6;
  localparam int unsigned RNG_LSB   = 2;
  localparam int unsigned OUT_BIT   = 1;
  localparam int unsigned T0X_BIT   = 0;
  localparam int unsigned CH_W      = 3;
  // reset values and writable masks
  localparam logic [7:0] CTRL0_RST  = 8'h00;
  localparam logic [7:0] CTRL1_RST  = 8'h00;
  localparam logic [7:0] CTRL0_WMSK = 8'hCD;
  localparam logic [7:0] CTRL1_WMSK = 8'h07;
  // current range codes and timer1 source code
  localparam logic [1:0] RNG_ZERO   = 2'h0;
  localparam logic [1:0] RNG_LOW    = 2'h1;
  localparam logic [1:0] RNG_MED    = 2'h2;
  localparam logic [1:0] T1_SRC_OSC = 2'h3;
  // device register select on the link
  localparam logic       SEL_CTRL0  = 1'b0;
  localparam logic       SEL_CTRL1  = 1'b1;
  // axi register byte offsets
  localparam logic [7:0] OFS_CTRL0  = 8'h00;
  localparam logic [7:0] OFS_CTRL1  = 8'h04;
  localparam logic [7:0] OFS_TCFG   = 8'h08;
  localparam logic [7:0] OFS_TMR0   = 8'h0C;
  localparam logic [7:0] OFS_TMR1   = 8'h10;
  // timer config field positions and reset value
  localparam int unsigned T0CS_BIT  = 0;
  localparam int unsigned T1CS_LSB  = 1;
  localparam int unsigned T1ON_BIT  = 3;
  localparam int unsigned T1GE_BIT  = 4;
  localparam int unsigned SLP_BIT   = 5;
  localparam int unsigned TGL_BIT   = 6;
  localparam logic [6:0] TCFG_RST   = 7'h00;
  // axi responses and system clock divide-by-four terminal count
  localparam logic [1:0] RESP_OKAY  = 2'h0;
  localparam logic [1:0] RESP_SLV   = 2'h2;
  localparam logic [1:0] FOSC_DIV   = 2'h3;

  // oscillator operating mode
  typedef enum logic [2:0] {
    CSC_OFF   = 3'b000,
    CSC_NOISE = 3'b001,
    CSC_LOW   = 3'b010,
    CSC_MED   = 3'b011,
    CSC_HIGH  = 3'b100
  } csc_mode_e;

  // decoded axi register
  typedef enum logic [2:0] {
    CSC_R_CTRL0 = 3'b000,
    CSC_R_CTRL1 = 3'b001,
    CSC_R_TCFG  = 3'b010,
    CSC_R_TMR0  = 3'b011,
    CSC_R_TMR1  = 3'b100,
    CSC_R_NONE  = 3'b111
  } csc_reg_e;
endpackage : csc_pkg

//--- common/csc_if.sv
// link between the sense control device and its timer/software end
`timescale 1ns/10ps
interface csc_if;
  logic       wr_en;
  logic       wr_sel;
  logic [7:0] wr_data;
  logic [7:0] ctrl0_rd;
  logic [7:0] ctrl1_rd;
  logic       tmr0_cs;
  logic [1:0] tmr1_cs;
  logic       sleep;
  logic       t0_tick;
  logic       t1_tick;

  modport dev (
    input  wr_en, wr_sel, wr_data, tmr0_cs, tmr1_cs, sleep,
    output ctrl0_rd, ctrl1_rd, t0_tick, t1_tick
  );
  modport ctl (
    output wr_en, wr_sel, wr_data, tmr0_cs, tmr1_cs, sleep,
    input  ctrl0_rd, ctrl1_rd, t0_tick, t1_tick
  );
endinterface : csc_if

//--- verilog/csc_dev.sv
// capacitive sense device end: control registers, mode decode, clock routing
`timescale 1ns/10ps

module csc_dev
  import csc_pkg::*;
(
  // clock and reset
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  // link to the timer end
  csc_if.dev                         link,
  // comparator output of the analog oscillator, high while sourcing
  input  wire logic                  osc_cmp,
  // analog controls
  output      logic                  ref_variable,
  output      csc_pkg::csc_mode_e    osc_mode,
  output      logic                  src_en,
  output      logic                  cmp_en,
  output      logic [2**CH_W-1:0]    chan_en
);
  import csc_pkg::*;

  // one enable per selectable input channel
  localparam int unsigned CH_N = 2**CH_W;

  // register state and next values
  logic [7:0]      ctrl0_q;
  logic [7:0]      ctrl0_d;
  logic [7:0]      ctrl1_q;
  logic [7:0]      ctrl1_d;
  logic [2:0]      sync_q;
  logic [2:0]      sync_d;
  logic [7:0]      rd0_q;
  logic [7:0]      rd0_d;
  logic [7:0]      rd1_q;
  logic [7:0]      rd1_d;
  logic            t0_q;
  logic            t0_d;
  logic            t1_q;
  logic            t1_d;
  logic            refv_q;
  logic            refv_d;
  csc_mode_e       mode_q;
  csc_mode_e       mode_d;
  logic            src_q;
  logic            src_d;
  logic            cmp_q;
  logic            cmp_d;
  logic [CH_N-1:0] chan_q;
  logic [CH_N-1:0] chan_d;
  // decoded fields and the oscillator edge
  logic            en;
  logic            rm;
  logic [1:0]      rng;
  logic            edge_up;
  logic            osc_run;

  // one-hot channel enable, nothing selected while off
  function automatic logic [CH_N-1:0] chan_onehot(input logic on,
                                                  input logic [CH_W-1:0] ch);
    logic [CH_N-1:0] v;
    v = '0;
    if (on) begin
      v[ch] = 1'b1;
    end
    return v;
  endfunction : chan_onehot

  // field views of the control register
  assign en  = ctrl0_q[EN_BIT];
  assign rm  = ctrl0_q[RM_BIT];
  assign rng = ctrl0_q[RNG_LSB+:2];
  // the tap flop adds no cycle to the tick; it only holds the last settled level for the edge
  // sync_q[0] is read only by sync_q[1]; edge uses the settled taps
  assign edge_up = sync_q[1] & ~sync_q[2];

  // control register writes from the timer end
  always_comb begin
    ctrl0_d = ctrl0_q;
    ctrl1_d = ctrl1_q;
    // masks keep reserved and status bits at zero in storage
    if (link.wr_en && link.wr_sel == SEL_CTRL0) begin
      ctrl0_d = link.wr_data & CTRL0_WMSK;
    end
    if (link.wr_en && link.wr_sel == SEL_CTRL1) begin
      ctrl1_d = link.wr_data & CTRL1_WMSK;
    end
  end

  // control registers, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl0_q <= CTRL0_RST;
      ctrl1_q <= CTRL1_RST;
    end else begin
      ctrl0_q <= ctrl0_d;
      ctrl1_q <= ctrl1_d;
    end
  end

  // comparator shift chain; only the second flop feeds the edge tap
  always_comb begin
    sync_d = {sync_q[1:0], osc_cmp};
  end

  // comparator is asynchronous to aclk, so it settles through two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync_q <= 3'h0;
    end else begin
      sync_q <= sync_d;
    end
  end

  // mode decode, channel select and tick routing
  always_comb begin
    // mode follows the current control value
    mode_d = CSC_OFF;
    if (en) begin
      case (rng)
        RNG_ZERO: begin
          mode_d = rm ? CSC_NOISE : CSC_OFF;
        end
        RNG_LOW: begin
          mode_d = CSC_LOW;
        end
        RNG_MED: begin
          mode_d = CSC_MED;
        end
        default: begin
          mode_d = CSC_HIGH;
        end
      endcase
    end
    // code 00 stops the oscillator only with fixed references
    osc_run = (mode_d != CSC_OFF);
    refv_d  = rm;
    // noise mode keeps comparator and pin alive, source off
    src_d   = osc_run && (mode_d != CSC_NOISE);
    cmp_d   = osc_run;
    // channel field is only a request; the enable bit gates it
    chan_d  = chan_onehot(en, ctrl1_q[CH_W-1:0]);
    // three edges from comparator to tick: two sync flops, then the output flop; the tap adds none
    // no edges leave a disabled or stopped oscillator
    t0_d = osc_run && edge_up && ctrl0_q[T0X_BIT]
           && link.tmr0_cs
           && !link.sleep;
    // timer0 is frozen in sleep, so only timer1 can measure while asleep
    // sleep does not stop the timer1 path
    t1_d = osc_run && edge_up && (link.tmr1_cs == T1_SRC_OSC);
    // status bit shows the synchronised comparator level
    rd0_d = {ctrl0_q[7:2], sync_q[1], ctrl0_q[T0X_BIT]};
    rd1_d = ctrl1_q;
  end

  // decoded outputs and ticks, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd0_q   <= CTRL0_RST;
      rd1_q   <= CTRL1_RST;
      t0_q    <= 1'b0;
      t1_q    <= 1'b0;
      refv_q  <= 1'b0;
      mode_q  <= CSC_OFF;
      src_q   <= 1'b0;
      cmp_q   <= 1'b0;
      chan_q  <= '0;
    end else begin
      rd0_q   <= rd0_d;
      rd1_q   <= rd1_d;
      t0_q    <= t0_d;
      t1_q    <= t1_d;
      refv_q  <= refv_d;
      mode_q  <= mode_d;
      src_q   <= src_d;
      cmp_q   <= cmp_d;
      chan_q  <= chan_d;
    end
  end

  // outputs straight from flops
  assign link.ctrl0_rd = rd0_q;
  assign link.ctrl1_rd = rd1_q;
  assign link.t0_tick  = t0_q;
  assign link.t1_tick  = t1_q;
  assign ref_variable  = refv_q;
  assign osc_mode      = mode_q;
  assign src_en        = src_q;
  assign cmp_en        = cmp_q;
  assign chan_en       = chan_q;
endmodule : csc_dev

//--- verilog/csc_ctl.sv
// timer end: axi4-lite registers, timer0 and timer1 counting oscillator ticks
//
// Added by the designer: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module csc_ctl
  import csc_pkg::*;
#(
  parameter int unsigned T0_W = 8,
  parameter int unsigned T1_W = 16
) (
  // clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // axi4-lite slave
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output      logic        s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output      logic        s_axi_wready,
  output      logic [1:0]  s_axi_bresp,
  output      logic        s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output      logic        s_axi_arready,
  output      logic [31:0] s_axi_rdata,
  output      logic [1:0]  s_axi_rresp,
  output      logic        s_axi_rvalid,
  input  wire logic        s_axi_rready,
  // link to the device, timer1 gate pin
  csc_if.ctl               link,
  input  wire logic        t1_gate_pin
);
  import csc_pkg::*;

  logic            awr_q, awr_d, wr_q, wr_d, bv_q, bv_d, arr_q, arr_d, rv_q, rv_d;
  logic            awf_q, awf_d, wf_q, wf_d;
  logic [7:0]      awa_q, awa_d;
  logic [31:0]     wd_q, wd_d, rd_q, rd_d;
  logic [3:0]      ws_q, ws_d;
  logic [1:0]      br_q, br_d, rr_q, rr_d;
  logic            lwr_q, lwr_d, lsel_q, lsel_d;
  logic [7:0]      ldat_q, ldat_d;
  logic [6:0]      cfg_q, cfg_d;
  logic [1:0]      div_q, div_d, gs_q, gs_d;
  logic            tgl_q, tgl_d;
  logic [T0_W-1:0] t0_q, t0_d;
  logic [T1_W-1:0] t1_q, t1_d;
  logic            t0_inc, t0_ovf, t1_inc, gate, do_wr;
  csc_reg_e        wsel, rsel;

  // byte offset to register, ignores the two low address bits
  function automatic csc_reg_e dec(input logic [7:0] a);
    case ({a[7:2], 2'b00})
      OFS_CTRL0: dec = CSC_R_CTRL0;
      OFS_CTRL1: dec = CSC_R_CTRL1;
      OFS_TCFG:  dec = CSC_R_TCFG;
      OFS_TMR0:  dec = CSC_R_TMR0;
      OFS_TMR1:  dec = CSC_R_TMR1;
      default:   dec = CSC_R_NONE;
    endcase
  endfunction : dec

  assign wsel  = dec(awa_q);
  assign rsel  = dec(s_axi_araddr);
  assign do_wr = awf_q && wf_q && !bv_q;

  // bus handshakes, timers and link drive
  always_comb begin
    awa_d = awa_q;
    wd_d  = wd_q;
    ws_d  = ws_q;
    awf_d = awf_q | (s_axi_awvalid & awr_q);
    wf_d  = wf_q | (s_axi_wvalid & wr_q);
    if (s_axi_awvalid && awr_q) begin
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wr_q) begin
      wd_d = s_axi_wdata;
      ws_d = s_axi_wstrb;
    end
    bv_d   = bv_q & ~s_axi_bready;
    br_d   = br_q;
    lwr_d  = 1'b0;
    lsel_d = lsel_q;
    ldat_d = ldat_q;
    cfg_d  = cfg_q;
    // timer0: system clock over four, or device ticks; frozen in sleep
    div_d  = div_q + 2'h1;
    t0_inc = !cfg_q[SLP_BIT] && (cfg_q[T0CS_BIT] ? link.t0_tick
                                                 : (div_q == FOSC_DIV));
    t0_ovf = t0_inc && (t0_q == {T0_W{1'b1}});
    t0_d   = t0_inc ? t0_q + {{(T0_W-1){1'b0}}, 1'b1} : t0_q;
    // toggle gate built from the timer0 overflow
    tgl_d  = tgl_q ^ t0_ovf;
    gate   = cfg_q[TGL_BIT] ? tgl_q : gs_q[1];
    t1_inc = cfg_q[T1ON_BIT] && (!cfg_q[T1GE_BIT] || gate)
             && (cfg_q[T1CS_LSB+:2] == T1_SRC_OSC) && link.t1_tick;
    t1_d   = t1_inc ? t1_q + {{(T1_W-1){1'b0}}, 1'b1} : t1_q;
    gs_d   = {gs_q[0], t1_gate_pin};
    if (do_wr) begin
      awf_d = 1'b0;
      wf_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = (wsel == CSC_R_NONE) ? RESP_SLV : RESP_OKAY;
      if (ws_q[0]) begin
        case (wsel)
          CSC_R_CTRL0, CSC_R_CTRL1: begin
            lwr_d  = 1'b1;
            lsel_d = (wsel == CSC_R_CTRL1) ? SEL_CTRL1 : SEL_CTRL0;
            ldat_d = wd_q[7:0];
          end
          CSC_R_TCFG: begin
            cfg_d = wd_q[6:0];
          end
          CSC_R_TMR0: begin
            t0_d = wd_q[T0_W-1:0];
          end
          CSC_R_TMR1: begin
            t1_d[7:0] = wd_q[7:0];
          end
          default: begin
            cfg_d = cfg_q;
          end
        endcase
      end
      if (ws_q[1] && wsel == CSC_R_TMR1) begin
        t1_d[T1_W-1:8] = wd_q[T1_W-1:8];
      end
    end
    awr_d = !awf_d && !bv_d;
    wr_d  = !wf_d && !bv_d;
    // read: one outstanding, data held until rready
    rv_d  = rv_q & ~s_axi_rready;
    rd_d  = rd_q;
    rr_d  = rr_q;
    if (s_axi_arvalid && arr_q) begin
      rv_d = 1'b1;
      rr_d = RESP_OKAY;
      case (rsel)
        CSC_R_CTRL0: rd_d = {24'h000000, link.ctrl0_rd};
        CSC_R_CTRL1: rd_d = {24'h000000, link.ctrl1_rd};
        CSC_R_TCFG:  rd_d = {25'h0000000, cfg_q};
        CSC_R_TMR0:  rd_d = {{(32-T0_W){1'b0}}, t0_q};
        CSC_R_TMR1:  rd_d = {{(32-T1_W){1'b0}}, t1_q};
        default: begin
          rd_d = 32'h00000000;
          rr_d = RESP_SLV;
        end
      endcase
    end
    arr_d = !rv_d;
  end

  // state registers, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      {awr_q, wr_q, arr_q} <= 3'h0;
      {bv_q, rv_q, awf_q, wf_q} <= 4'h0;
      awa_q <= 8'h00;
      wd_q <= 32'h00000000;
      rd_q <= 32'h00000000;
      ws_q <= 4'h0;
      br_q <= RESP_OKAY;
      rr_q <= RESP_OKAY;
      lwr_q <= 1'b0;
      lsel_q <= SEL_CTRL0;
      ldat_q <= 8'h00;
      cfg_q <= TCFG_RST;
      div_q <= 2'h0;
      gs_q <= 2'h0;
      tgl_q <= 1'b0;
      t0_q <= '0;
      t1_q <= '0;
    end else begin
      {awr_q, wr_q, arr_q} <= {awr_d, wr_d, arr_d};
      {bv_q, rv_q, awf_q, wf_q} <= {bv_d, rv_d, awf_d, wf_d};
      awa_q <= awa_d;
      wd_q <= wd_d;
      rd_q <= rd_d;
      ws_q <= ws_d;
      br_q <= br_d;
      rr_q <= rr_d;
      lwr_q <= lwr_d;
      lsel_q <= lsel_d;
      ldat_q <= ldat_d;
      cfg_q <= cfg_d;
      div_q <= div_d;
      gs_q <= gs_d;
      tgl_q <= tgl_d;
      t0_q <= t0_d;
      t1_q <= t1_d;
    end
  end

  // timer1 measures the oscillator, so the time base comes from timer0
  assign s_axi_awready = awr_q;
  assign s_axi_wready  = wr_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_arready = arr_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rdata   = rd_q;
  assign s_axi_rresp   = rr_q;
  assign link.wr_en    = lwr_q;
  assign link.wr_sel   = lsel_q;
  assign link.wr_data  = ldat_q;
  assign link.tmr0_cs  = cfg_q[T0CS_BIT];
  assign link.tmr1_cs  = cfg_q[T1CS_LSB+:2];
  assign link.sleep    = cfg_q[SLP_BIT];
endmodule : csc_ctl

//--- dv/csc_monitor.sv
// checker of the link between the sense device and its timer end
`timescale 1ns/10ps
module csc_monitor
  import csc_pkg::*;
(
  // clock, reset and link signals
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       wr_en,
  input wire logic       wr_sel,
  input wire logic [7:0] wr_data,
  input wire logic [7:0] ctrl0_rd,
  input wire logic [7:0] ctrl1_rd,
  input wire logic       tmr0_cs,
  input wire logic [1:0] tmr1_cs,
  input wire logic       sleep,
  input wire logic       t0_tick,
  input wire logic       t1_tick
);
  logic [7:0] wd_q;
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // last written byte, kept since wr_data may move on before readback
  always_ff @(posedge aclk) begin
    if (wr_en) wd_q <= wr_data;
  end
  // readback is one flop behind the register, as is the tick flop
  chk_t0_enable: assert property (t0_tick |-> ctrl0_rd[EN_BIT])
    else $error("timer0 tick while disabled");
  chk_t1_enable: assert property (t1_tick |-> ctrl0_rd[EN_BIT])
    else $error("timer1 tick while disabled");
  chk_t0_route: assert property (t0_tick |-> ctrl0_rd[T0X_BIT] && $past(tmr0_cs))
    else $error("timer0 tick without routing");
  chk_t0_sleep: assert property (t0_tick |-> !$past(sleep))
    else $error("timer0 tick in sleep");
  chk_t1_source: assert property (t1_tick |-> $past(tmr1_cs) == T1_SRC_OSC)
    else $error("timer1 tick from wrong source");
  chk_fixed_off: assert property ((t0_tick || t1_tick) |->
    (ctrl0_rd[RM_BIT] || ctrl0_rd[3:2] != RNG_ZERO)) else $error("tick while oscillator off");
  chk_tick_pulse: assert property (t1_tick |=> !t1_tick)
    else $error("timer1 tick longer than one cycle");
  chk_rsvd_zero: assert property (ctrl0_rd[5:4] == 2'h0 && ctrl1_rd[7:3] == 5'h0)
    else $error("unused bits read nonzero");
  chk_ctrl0_write: assert property (wr_en && wr_sel == SEL_CTRL0 |=> ##[0:2]
    (ctrl0_rd & CTRL0_WMSK) == (wd_q & CTRL0_WMSK)) else $error("control0 write lost");
  chk_ctrl1_write: assert property (wr_en && wr_sel == SEL_CTRL1 |=> ##[0:2]
    ctrl1_rd[2:0] == wd_q[2:0]) else $error("control1 write lost");
endmodule : csc_monitor

//--- dv/tb_top.sv
// self-checking bench joining the sense device and timer end
`timescale 1ns/10ps
module tb_top;
  import csc_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, osc, gate;
  logic        awready, wready, bvalid, arready, rvalid, ref_var, src_en, cmp_en;
  logic [7:0]  awaddr, araddr, chan_en;
  logic [31:0] wdata, rdata, v, r;
  logic [1:0]  bresp, rresp;
  logic [65:0] ent;
  logic [65:0] exp_q[$];
  csc_mode_e   mode;
  integer      fail_count, compares, cyc, seed, i;
  // ctrl0, timer cfg, gate, timer0 and timer1 counts after four pulses
  logic [31:0] tbl [10] = '{32'h850F0440,
    32'h852F0040, 32'h050F0000, 32'h810F0000,
    32'hC10F0440, 32'h840F0040, 32'h85070400,
    32'h851F0400, 32'h851F1440, 32'h850D0400};
  csc_if link ();
  csc_dev i_csc_dev (.aclk(aclk), .aresetn(aresetn), .link(link.dev), .osc_cmp(osc),
    .ref_variable(ref_var), .osc_mode(mode), .src_en(src_en), .cmp_en(cmp_en),
    .chan_en(chan_en));
  csc_ctl i_csc_ctl (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link(link.ctl),
    .t1_gate_pin(gate));
  csc_monitor i_csc_monitor (.aclk(aclk), .aresetn(aresetn), .wr_en(link.wr_en),
    .wr_sel(link.wr_sel), .wr_data(link.wr_data), .ctrl0_rd(link.ctrl0_rd),
    .ctrl1_rd(link.ctrl1_rd), .tmr0_cs(link.tmr0_cs), .tmr1_cs(link.tmr1_cs),
    .sleep(link.sleep), .t0_tick(link.t0_tick), .t1_tick(link.t1_tick));
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end
  task automatic final_report;
    $display("errors %0d compares %0d", fail_count, compares);
    if (fail_count == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : final_report
  task automatic check(input logic [33:0] seen, input logic [33:0] expv);
    compares = compares + 1;
    if (seen !== expv) begin
      fail_count = fail_count + 1;
      $display("Error at %0t: saw %h expected %h", $time, seen, expv);
    end
  endtask : check
  // write: both channels offered at once, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    exp_q.push_back({32'h0, er, 32'h0});
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    ad = 1'b0; wd = 1'b0;
    do begin
      @(posedge aclk);
      if (awready) begin ad = 1'b1; awvalid <= 1'b0; end
      if (wready) begin wd = 1'b1; wvalid <= 1'b0; end
    end while (!(ad && wd));
    while (!bvalid) @(posedge aclk);
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [1:0] er,
                    input logic [31:0] ed);
    exp_q.push_back({m, er, ed & m});
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    while (!rvalid) @(posedge aclk);
    rready <= 1'b0;
  endtask : rd
  // slow triangle stand-in: eight cycles a period, idle low
  task automatic pulses(input int n);
    repeat (n) begin
      osc <= 1'b1; repeat (4) @(posedge aclk);
      osc <= 1'b0; repeat (4) @(posedge aclk);
    end
  endtask : pulses
  task automatic mode_chk(input logic [7:0] c0, input logic [7:0] c1);
    logic [1:0] rg;
    csc_mode_e  em;
    rg = c0[3:2];
    em = !c0[EN_BIT] ? CSC_OFF : rg == RNG_ZERO ? (c0[RM_BIT] ? CSC_NOISE : CSC_OFF) :
         rg == RNG_LOW ? CSC_LOW : rg == RNG_MED ? CSC_MED : CSC_HIGH;
    wr(OFS_CTRL1, {24'h0, c1}, RESP_OKAY);
    wr(OFS_CTRL0, {24'h0, c0}, RESP_OKAY);
    repeat (4) @(posedge aclk);
    check({31'h0, mode}, {31'h0, em});
    check({33'h0, src_en}, {33'h0, em != CSC_OFF && em != CSC_NOISE});
    check({33'h0, cmp_en}, {33'h0, em != CSC_OFF});
    check({33'h0, ref_var}, {33'h0, c0[RM_BIT]});
    check({26'h0, chan_en}, {26'h0, c0[EN_BIT] ? 8'h01 << c1[2:0] : 8'h00});
    rd(OFS_CTRL0, 32'hFF, RESP_OKAY, {24'h0, c0 & CTRL0_WMSK});
    rd(OFS_CTRL1, 32'hFF, RESP_OKAY, {24'h0, c1 & CTRL1_WMSK});
  endtask : mode_chk
  // scoreboard: oldest note against each answer
  always @(posedge aclk) begin
    if ((bvalid && bready) || (rvalid && rready)) begin
      ent = exp_q.pop_front();
      check(bvalid ? {bresp, 32'h0} : {rresp, rdata & ent[65:34]}, ent[33:0]);
    end
  end
  // hang guard
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count = fail_count + 1;
      final_report();
    end
  end
  initial begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; osc = 1'b0; gate = 1'b0; awaddr = 8'h00; araddr = 8'h00;
    wdata = 32'h0; fail_count = 0; compares = 0; cyc = 0; seed = 32'h6c75;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    // timer0 counts aclk over four from reset: three steps by the time it is read
    for (i = 0; i < 5; i++) begin
      rd(OFS_CTRL0 + 8'(4 * i), 32'hFFFFFFFF, RESP_OKAY, (i == 3) ? 32'h3 : 32'h0);
    end
    wr(8'h14, 32'hFF, RESP_SLV);
    rd(8'h14, 32'hFFFFFFFF, RESP_SLV, 32'h0);
    for (i = 0; i < 16; i++) begin
      v = $random(seed);
      mode_chk({i[3], i[2], v[5:4], i[1:0], v[1:0]}, v[15:8]);
    end
    osc <= 1'b1;
    repeat (4) @(posedge aclk);
    rd(OFS_CTRL0, 32'h2, RESP_OKAY, 32'h2);
    osc <= 1'b0;
    for (i = 0; i < 10; i++) begin
      r = tbl[i];
      gate <= r[12];
      wr(OFS_CTRL0, {24'h0, r[31:24]}, RESP_OKAY);
      wr(OFS_TCFG, {24'h0, r[23:16]}, RESP_OKAY);
      wr(OFS_TMR0, 32'h0, RESP_OKAY);
      wr(OFS_TMR1, 32'h0, RESP_OKAY);
      pulses(4);
      repeat (6) @(posedge aclk);
      rd(OFS_TMR0, 32'hFF, RESP_OKAY, {28'h0, r[11:8]});
      rd(OFS_TMR1, 32'hFFFF, RESP_OKAY, {28'h0, r[7:4]});
    end
    // internal source: about 171 cycles over four gives 0x28 to 0x2F
    wr(OFS_CTRL0, 32'h85, RESP_OKAY);
    wr(OFS_TCFG, 32'h0E, RESP_OKAY);
    wr(OFS_TMR0, 32'h0, RESP_OKAY);
    pulses(21);
    rd(OFS_TMR0, 32'hF8, RESP_OKAY, 32'h28);
    // toggle gate: one window on each side of a timer0 overflow, so exactly one counts
    wr(OFS_TCFG, 32'h5E, RESP_OKAY);
    wr(OFS_TMR0, 32'hE0, RESP_OKAY);
    wr(OFS_TMR1, 32'h0, RESP_OKAY);
    pulses(4);
    // overflow falls about 128 cycles after the timer0 load, well inside this gap
    repeat (120) @(posedge aclk);
    pulses(4);
    repeat (6) @(posedge aclk);
    rd(OFS_TMR1, 32'hFFFF, RESP_OKAY, 32'h4);
    repeat (4) @(posedge aclk);
    final_report();
  end
endmodule : tb_top
